// ==== logic/pfs_fault_signal.v ====
// fault signalling, force-off gating, wake and recovery logic of the pack monitor
`timescale 1ns/10ps
`default_nettype none
`include "pfs_map.vh"
module pfs_fault_signal
(
    input  wire                      clk_sys,
    input  wire                      rstn,
    // host link status from the serial slave
    input  wire                      host_attached,
    input  wire                      slave_byte_rx,
    input  wire [`PFS_WDOG_W-1:0]    wdog_period,
    input  wire                      addr_strap,
    input  wire                      serial_data_in,
    input  wire                      serial_sda_drive_low,
    // detector outputs, same clock
    input  wire                      overvoltage_lockout,
    input  wire                      cell_mismatch,
    input  wire                      cell_mismatch_en,
    input  wire                      open_wire,
    input  wire                      open_wire_en,
    input  wire                      undervoltage,
    input  wire                      temp_fault,
    input  wire                      dsg_overcurrent,
    input  wire                      short_circuit,
    input  wire                      chg_overcurrent,
    input  wire                      overvoltage,
    input  wire [`PFS_CELLS-1:0]     cell_over_eoc,
    // pins from outside the clock domain
    input  wire                      force_switches_off,
    input  wire                      charger_sense,
    input  wire                      load_sense,
    // switch requests
    input  wire                      sleep_mode,
    input  wire [`PFS_SW_N-1:0]      host_switch_on,
    input  wire [`PFS_CELLS-1:0]     balance_req,
    // outputs
    output reg                       host_alert_n,
    output reg                       pack_fuse_request,
    output reg                       discharge_fault_out,
    output reg                       discharge_fault_oe_n,
    output reg                       end_of_charge,
    output reg                       wake,
    output reg  [`PFS_SW_N-1:0]      power_switch,
    output reg  [`PFS_CELLS-1:0]     balance_switch,
    output reg                       serial_data_out,
    output reg  [`PFS_ADDR_W-1:0]    target_addr,
    output reg                       switch_refused
);
    // recovery states of the power path
    localparam ST_RUN      = 2'd0;
    localparam ST_CHG_WAIT = 2'd1;
    localparam ST_DSG_WAIT = 2'd2;

    // an optional fault source counts only while its option bit is set
    function opt_fault;
        input src;
        input en;
        begin
            opt_fault = src & en;
        end
    endfunction

    // discharge-side trips; both start the wait for load removal
    function dsg_trip;
        input dsg_oc;
        input short_c;
        begin
            dsg_trip = dsg_oc | short_c;
        end
    endfunction

    // precharge yields to charge; the two paths must never conduct together
    function [`PFS_SW_N-1:0] sw_interlock;
        input [`PFS_SW_N-1:0] req;
        begin
            sw_interlock = req;
            if (req[`PFS_SW_CHARGE])
                sw_interlock[`PFS_SW_PRECHARGE] = 1'b0;
        end
    endfunction

    // synchronised copies of the three pins
    wire                   force_off_s;
    wire                   charger_s;
    wire                   load_s;
    reg  [`PFS_WDOG_W-1:0] wdog_reg;
    reg  [1:0]             state_reg;
    reg  [1:0]             state_next;
    reg                    charger_d_reg;
    reg                    load_d_reg;
    reg                    strap_done_reg;
    reg  [`PFS_SW_N-1:0]   sw_next;
    wire                   dsg_off_fault;
    wire                   any_fault;
    wire                   recovering;
    wire                   mismatch_hit;
    wire                   open_wire_hit;

    // external pins are asynchronous to clk_sys
    // a pin change reaches the logic three to four cycles later
    pfs_sync3 u_sync_off
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (force_switches_off),
        .dout    (force_off_s)
    );
    pfs_sync3 u_sync_chg
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (charger_sense),
        .dout    (charger_s)
    );
    pfs_sync3 u_sync_load
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (load_sense),
        .dout    (load_s)
    );

    // option-gated sources, shared by the fuse request and the fault summary
    assign mismatch_hit  = opt_fault(cell_mismatch, cell_mismatch_en);
    assign open_wire_hit = opt_fault(open_wire, open_wire_en);

    // faults that open the discharge path; lockout counts as one
    assign dsg_off_fault = undervoltage
                         | temp_fault
                         | dsg_trip(dsg_overcurrent, short_circuit)
                         | overvoltage_lockout;
    // any out-of-bounds condition; blocks every host switch request
    assign any_fault     = dsg_off_fault
                         | chg_overcurrent
                         | overvoltage
                         | mismatch_hit
                         | open_wire_hit;
    assign recovering    = (state_reg != ST_RUN);

    // communication watchdog; alert holds until the next byte arrives
    // the counter parks at zero once expired, so a late byte reloads a full period
    // with no host attached the counter is held loaded and the alert stays quiet
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            wdog_reg     <= `PFS_WDOG_DEFAULT;
            host_alert_n <= 1'b1;
        end
        else if (!host_attached)
        begin
            wdog_reg     <= wdog_period;
            host_alert_n <= 1'b1;
        end
        else if (slave_byte_rx)
        begin
            wdog_reg     <= wdog_period;
            host_alert_n <= 1'b1;
        end
        else if (wdog_reg == {`PFS_WDOG_W{1'b0}})
            host_alert_n <= 1'b0;
        else
            wdog_reg <= wdog_reg - 1'b1;
    end

    // overcurrent recovery; while waiting, a trip on the other side is not tracked
    // the switches stay off until the fault is gone and the sense pin reads idle,
    // so a charger or load left in place cannot re-trip the path at once
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (chg_overcurrent)
                    state_next = ST_CHG_WAIT;
                else if (dsg_trip(dsg_overcurrent, short_circuit))
                    state_next = ST_DSG_WAIT;
            end
            ST_CHG_WAIT:
            begin
                if (!chg_overcurrent && !charger_s)
                    state_next = ST_RUN;
            end
            ST_DSG_WAIT:
            begin
                if (!dsg_trip(dsg_overcurrent, short_circuit) && !load_s)
                    state_next = ST_RUN;
            end
            default:
                state_next = ST_RUN;
        endcase
    end

    // power switch requests gated by faults, recovery and force-off
    // a blocked request is dropped here; switch_refused flags a fault or recovery block, not force-off
    always @*
    begin
        sw_next = host_switch_on;
        if (any_fault)
            sw_next = {`PFS_SW_N{1'b0}};
        if (recovering || state_next != ST_RUN)
            sw_next = {`PFS_SW_N{1'b0}};
        if (force_off_s)
            sw_next = {`PFS_SW_N{1'b0}};
        // charge and precharge never together; precharge yields
        sw_next = sw_interlock(sw_next);
    end

    // registered fault outputs and switch drives
    // every pin comes from a flop, so decode glitches never reach the board
    // the cost is one cycle of extra latency on each fault indication
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            state_reg            <= ST_RUN;
            pack_fuse_request    <= 1'b0;
            discharge_fault_out  <= 1'b0;
            discharge_fault_oe_n <= 1'b1;
            end_of_charge        <= 1'b0;
            power_switch         <= {`PFS_SW_N{1'b0}};
            balance_switch       <= {`PFS_CELLS{1'b0}};
            switch_refused       <= 1'b0;
        end
        else
        begin
            state_reg         <= state_next;
            pack_fuse_request <= overvoltage_lockout
                               | mismatch_hit
                               | open_wire_hit;
            // open drain: pull low only when a fault is present
            discharge_fault_out  <= 1'b0;
            discharge_fault_oe_n <= ~(dsg_off_fault
                                    | chg_overcurrent);
            end_of_charge  <= |cell_over_eoc;
            power_switch   <= sw_next;
            balance_switch <= force_off_s ? {`PFS_CELLS{1'b0}} : balance_req;
            // refusal level ignores force-off, which the host already knows about
            switch_refused <= (|host_switch_on) & (any_fault | recovering);
        end
    end

    // sleep wake on charger or load connect; edges avoid waking on a standing level
    // a pin already high when sleep begins gives no wake until it drops and rises
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            charger_d_reg <= 1'b0;
            load_d_reg    <= 1'b0;
            wake          <= 1'b0;
        end
        else
        begin
            charger_d_reg <= charger_s;
            load_d_reg    <= load_s;
            wake <= sleep_mode & ((charger_s & ~charger_d_reg)
                                | (load_s & ~load_d_reg));
        end
    end

    // serial data kept as separate in and out lines; address strap caught after reset
    // the strap is read once; moving it later takes a reset to show
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            serial_data_out <= 1'b1;
            target_addr     <= `PFS_ADDR_BASE;
            strap_done_reg  <= 1'b0;
        end
        else
        begin
            serial_data_out <= ~serial_sda_drive_low;
            if (!strap_done_reg)
            begin
                target_addr    <= `PFS_ADDR_BASE | {{(`PFS_ADDR_W-1){1'b0}}, addr_strap};
                strap_done_reg <= 1'b1;
            end
        end
    end
endmodule // pfs_fault_signal
`default_nettype wire

// ==== logic/pfs_map.vh ====
// constants for the pack fault signalling block
`ifndef PFS_MAP_VH
`define PFS_MAP_VH
`define PFS_WDOG_W        16
`define PFS_WDOG_DEFAULT  16'h4000
`define PFS_ADDR_W        7
`define PFS_ADDR_BASE     7'h28
`define PFS_ADDR_STRAP_B  0
`define PFS_CELLS         8
`define PFS_SW_N          3
`define PFS_SW_DISCHARGE  0
`define PFS_SW_CHARGE     1
`define PFS_SW_PRECHARGE  2
`endif

// ==== logic/pfs_sync3.v ====
// three-stage input synchroniser with agreement check
`timescale 1ns/10ps
`default_nettype none
module pfs_sync3
(
    input  wire clk_sys,
    input  wire rstn,
    input  wire din,
    output reg  dout
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // first stage feeds only the second; output moves once stages two and three agree
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                dout <= s3_reg;
        end
    end
endmodule // pfs_sync3
`default_nettype wire

// ==== verif/pfs_fault_props_properties.sv ====
// assertion checker for the pack fault signalling block
`timescale 1ns/10ps
`default_nettype none
module pfs_fault_props
(
    input wire logic       clk_sys, rstn, slave_byte_rx, serial_sda_drive_low,
    input wire logic       overvoltage_lockout, cell_mismatch, cell_mismatch_en,
    input wire logic       undervoltage, temp_fault, dsg_overcurrent, short_circuit,
    input wire logic       chg_overcurrent, force_switches_off, sleep_mode, charger_sense,
    input wire logic [7:0] cell_over_eoc, balance_switch,
    input wire logic [2:0] host_switch_on, power_switch,
    input wire logic       host_alert_n, pack_fuse_request, discharge_fault_oe_n,
    input wire logic       end_of_charge, serial_data_out, switch_refused, wake
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // the pin synchroniser needs several cycles, so hold long enough
    sequence s_force_held;
        force_switches_off [*7];
    endsequence
    sequence s_charger_plugged;
        sleep_mode && $rose(charger_sense) ##1 sleep_mode [*7];
    endsequence
    AST_FUSE_OVERVOLTAGE_LOCKOUT: assert property (overvoltage_lockout |=> pack_fuse_request)
        else $error("no fuse request on lockout");
    AST_FUSE_MIS: assert property (cell_mismatch && cell_mismatch_en |=> pack_fuse_request)
        else $error("no fuse request on mismatch");
    AST_SD_DSG: assert property ((undervoltage || temp_fault || dsg_overcurrent || short_circuit)
        |=> !discharge_fault_oe_n) else $error("discharge fault pin not pulled");
    AST_SD_CHG: assert property (chg_overcurrent |=> !discharge_fault_oe_n)
        else $error("charge overcurrent not flagged");
    AST_EOC: assert property (|cell_over_eoc |=> end_of_charge)
        else $error("end of charge missing");
    AST_SDO: assert property (serial_sda_drive_low |=> !serial_data_out)
        else $error("data out not pulled low");
    AST_REFUSE: assert property (|host_switch_on && overvoltage_lockout
        |=> switch_refused && power_switch == 3'h0) else $error("switch request not refused");
    AST_FORCE: assert property (s_force_held |-> power_switch == 3'h0 && balance_switch == 8'h0)
        else $error("switches on under force off");
    AST_ALERT_CLR: assert property (slave_byte_rx |=> host_alert_n)
        else $error("alert kept after byte");
    // pin seen at the first sample; three sync stages, the agreement flop and the edge flop put wake four
    // edges later, which is two or three samples before the end of the hold
    AST_WAKE_CHG: assert property (s_charger_plugged |-> $past(wake, 2) || $past(wake, 3))
        else $error("no wake on charger connect");
endmodule // pfs_fault_props
bind pfs_fault_signal pfs_fault_props u_props (.*);
`default_nettype wire

// ==== verif/pfs_host_model.sv ====
// host controller model: link byte pulses and the force-off pin
`timescale 1ns/10ps
`default_nettype none
module pfs_host_model
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       attach,
    input  wire logic [7:0] byte_gap,
    input  wire logic       fo_cmd,
    output var  logic       host_attached = 1'b0,
    output var  logic       slave_byte_rx = 1'b0,
    output var  logic       force_switches_off = 1'b0
);
    logic [7:0] gap_reg = 8'h0;
    // a zero gap models a host that has gone silent
    always @(posedge clk_sys)
    begin
        gap_reg <= (!rstn || !attach || gap_reg + 8'h1 >= byte_gap) ? 8'h0 : gap_reg + 8'h1;
        slave_byte_rx <= rstn && attach && byte_gap != 8'h0 && gap_reg + 8'h1 >= byte_gap;
        host_attached <= attach;
        force_switches_off <= fo_cmd;
    end
endmodule // pfs_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the pack fault signalling block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_sys = 1'b0, rstn = 1'b0, attach = 1'b0, fo_cmd = 1'b0, sleep = 1'b0;
    logic        strap = 1'b1, sdi = 1'b1, sda_low = 1'b0, chg_s = 1'b0, ld_s = 1'b0;
    logic [8:0]  f = 9'h0;
    logic [1:0]  en = 2'h0;
    logic [7:0]  byte_gap = 8'h0, over_eoc = 8'h0, bal_req = 8'ha5;
    logic [2:0]  sw_on = 3'h0;
    wire         att, rx, fo, alert_n, fuse, sd_out, oe_n, eoc, wake, sdo, refused;
    wire [2:0]   psw;
    wire [7:0]   bsw;
    wire [6:0]   taddr;
    int          errors = 0, checks_done = 0, cycles = 0;
    always #4 clk_sys = ~clk_sys;
    pfs_host_model host (.clk_sys(clk_sys), .rstn(rstn), .attach(attach), .byte_gap(byte_gap),
        .fo_cmd(fo_cmd), .host_attached(att), .slave_byte_rx(rx), .force_switches_off(fo));
    // fault vector order: lockout mismatch open uv temp dsg_oc short chg_oc ov
    pfs_fault_signal dut (.clk_sys(clk_sys), .rstn(rstn), .host_attached(att),
        .slave_byte_rx(rx), .wdog_period(16'h8), .addr_strap(strap), .serial_data_in(sdi),
        .serial_sda_drive_low(sda_low), .overvoltage_lockout(f[0]), .cell_mismatch(f[1]),
        .cell_mismatch_en(en[0]), .open_wire(f[2]), .open_wire_en(en[1]), .undervoltage(f[3]),
        .temp_fault(f[4]), .dsg_overcurrent(f[5]), .short_circuit(f[6]), .chg_overcurrent(f[7]),
        .overvoltage(f[8]), .cell_over_eoc(over_eoc), .force_switches_off(fo),
        .charger_sense(chg_s), .load_sense(ld_s), .sleep_mode(sleep), .host_switch_on(sw_on),
        .balance_req(bal_req), .host_alert_n(alert_n), .pack_fuse_request(fuse),
        .discharge_fault_out(sd_out), .discharge_fault_oe_n(oe_n), .end_of_charge(eoc),
        .wake(wake), .power_switch(psw), .balance_switch(bsw), .serial_data_out(sdo),
        .target_addr(taddr), .switch_refused(refused));
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // each option case pairs a source with its enable on and off
    task t_fuse;
        for (int i = 0; i < 5; i++)
        begin
            f = 9'h0;
            f[(i + 1) / 2] = 1'b1;
            en = (i % 2) ? 2'h0 : 2'h3;
            cyc(2);
            chk("fuse", fuse, (i % 2) ? 16'h0 : 16'h1);
        end
    endtask
    task t_sd_eoc;
        for (int i = 3; i < 8; i++)
        begin
            f = 9'h0;
            f[i] = 1'b1;
            cyc(2);
            chk("fault oe_n", oe_n, 16'h0);
        end
        // overvoltage alone is not a discharge-path fault, so the pin stays released
        f = 9'h100;
        cyc(2);
        chk("fault pin idle", {oe_n, sd_out}, 16'h2);
        f = 9'h0;
        for (int i = 0; i < 8; i++)
        begin
            over_eoc = 8'h1 << i;
            cyc(2);
            chk("eoc", eoc, 16'h1);
        end
        over_eoc = 8'h0;
        cyc(10);
    endtask
    // precharge is asked too; charge must win
    task t_switch;
        sw_on = 3'h7;
        cyc(8);
        chk("switches", {psw, bsw}, {5'h0, 3'h3, 8'ha5});
        f[8] = 1'b1;
        cyc(2);
        chk("refused", {refused, psw}, 16'h8);
        f = 9'h1;
        cyc(2);
        chk("refused lockout", {refused, psw}, 16'h8);
        f = 9'h0;
        fo_cmd = 1'b1;
        cyc(9);
        chk("forced off", {psw, bsw}, 16'h0);
        fo_cmd = 1'b0;
        cyc(8);
    endtask
    task t_recover(input int k);
        chg_s = (k == 7);
        ld_s = (k == 5);
        f[k] = 1'b1;
        cyc(8);
        f = 9'h0;
        cyc(8);
        chk("held off", psw, 16'h0);
        {chg_s, ld_s} = 2'h0;
        cyc(10);
        chk("restored", psw, 16'h3);
    endtask
    task t_wake(input int k);
        int n;
        n = 0;
        sw_on = 3'h0;
        sleep = 1'b1;
        cyc(8);
        chg_s = (k == 0);
        ld_s = (k == 1);
        repeat (10)
        begin
            cyc(1);
            n += wake;
        end
        chk("wake pulses", 16'(n), 16'h1);
        {chg_s, ld_s, sleep} = 3'h0;
        cyc(8);
    endtask
    // period 8: a silent host trips the alert, a 4-cycle byte rate keeps it clear
    task t_wdog;
        attach = 1'b1;
        cyc(20);
        chk("alert expired", alert_n, 16'h0);
        byte_gap = 8'h4;
        cyc(20);
        chk("alert held clear", alert_n, 16'h1);
        attach = 1'b0;
    endtask
    // hang guard well above the scenario run time
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            close_out;
        end
    end
    initial
    begin
        cyc(16);
        chk("reset outs", {alert_n, fuse, oe_n, eoc, wake, psw, bsw, sdo, refused}, 32'h28002);
        rstn = 1'b1;
        sda_low = 1'b1;
        cyc(3);
        chk("addr and data out", {taddr, sdo}, 16'h52);
        sda_low = 1'b0;
        t_fuse;
        t_sd_eoc;
        t_switch;
        t_recover(7);
        t_recover(5);
        t_wake(0);
        t_wake(1);
        t_wdog;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
